// [ddcm_regs.vh]
// Register indices, field positions, codes and reset values of the downconverter mode block
`ifndef DDCM_REGS_VH
`define DDCM_REGS_VH

// ----------
// Register indices (byte address is four times the index)
// ----------
`define DDCM_IDX_APP 10'h200
`define DDCM_IDX_DEC 10'h201
`define DDCM_IDX_STATUS 10'h202
`define DDCM_IDX_CTL0 10'h310
`define DDCM_IDX_SEL0 10'h311
`define DDCM_IDX_FTWA0 10'h314
`define DDCM_IDX_FTWB0 10'h315
`define DDCM_IDX_POWA0 10'h320
`define DDCM_IDX_POWB0 10'h321
`define DDCM_IDX_CTL1 10'h330
`define DDCM_IDX_SEL1 10'h331
`define DDCM_IDX_FTWA1 10'h334
`define DDCM_IDX_FTWB1 10'h335
`define DDCM_IDX_POWA1 10'h340
`define DDCM_IDX_POWB1 10'h341

// ----------
// Application and decimation codes
// ----------
`define DDCM_APP_ONE_IQ 8'h01
`define DDCM_APP_TWO_IQ 8'h02
`define DDCM_APP_TWO_I 8'h22
`define DDCM_DEC_BY2 8'h01
`define DDCM_DEC_BY4 8'h02

// ----------
// Field positions
// ----------
`define DDCM_CTL_CMIX 7
`define DDCM_CTL_GAIN 6
`define DDCM_CTL_REAL 3
`define DDCM_CTL_CHAIN_HI 1
`define DDCM_CTL_CHAIN_LO 0
`define DDCM_SEL_I 0
`define DDCM_SEL_Q 2

// ----------
// Reset values
// ----------
`define DDCM_RST_APP 8'h01
`define DDCM_RST_DEC 8'h01
`define DDCM_RST_CTL 8'h83
`define DDCM_RST_SEL 8'h04
`define DDCM_RST_WORD 8'h00

`endif

// [ddcm_ahb_slave.v]
// AHB-Lite slave front end for the downconverter mode registers
`timescale 1ns/1ps

module ddcm_ahb_slave (
    input wire clock, // System clock
    input wire rst_b, // Asynchronous reset, active low
    input wire hsel, // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write when high
    input wire [2:0] hsize, // Transfer size, word only
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready
    output wire hreadyout, // Always ready, no wait states
    output wire hresp, // Always OKAY
    output reg [31:0] hrdata, // Read data, registered
    output wire wr_en, // Register write strobe
    output reg [9:0] wr_idx, // Register index being written
    output wire [7:0] wr_data, // Write byte
    output wire [9:0] rd_idx, // Index looked up in address phase
    input wire [7:0] rd_data // Looked-up read byte
);

    // ----------
    // Address phase decode
    // ----------
    wire take = hsel & htrans[1] & hready;
    // Anything above the 4 KB window is unmapped
    wire mapped = (haddr[31:12] == 20'h00000);
    reg wr_pend_q;

    assign rd_idx = haddr[11:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Write lands during the data phase, when hwdata is valid
    assign wr_en = wr_pend_q;
    assign wr_data = hwdata[7:0];

    // Capture write intent and read data at the address phase
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_idx <= 10'h000;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_q <= take & hwrite & mapped;
            if (take) begin
                wr_idx <= haddr[11:2];
                // Unmapped or write: data phase reads as zero
                hrdata <= (!hwrite && mapped) ? {24'h000000, rd_data} : 32'h00000000;
            end
        end
    end

endmodule // ddcm_ahb_slave

// [ddcm_path.v]
// One downconverter lane: input routing, gain, mixer choice, real conversion, decimation
`timescale 1ns/1ps

module ddcm_path #(
    parameter W = 14 // Sample width
) (
    input wire clock, // System clock
    input wire rst_b, // Asynchronous reset, active low
    input wire enable, // Lane runs when high
    input wire [W-1:0] sample_a, // Converter channel A sample
    input wire [W-1:0] sample_b, // Converter channel B sample
    input wire sample_valid, // Sample strobe, same clock
    input wire sel_i_b, // I input from channel B
    input wire sel_q_b, // Q input from channel B
    input wire complex_mixer, // Complex mixer when high, real otherwise
    input wire gain_6db, // 6 dB gain when high
    input wire real_out, // Real output when high
    input wire [1:0] chain_code, // Filter chain length code
    output reg [W-1:0] out_i, // I (or real) output
    output reg [W-1:0] out_q, // Q output, zero on real output
    output reg out_valid, // One-cycle output strobe
    output wire [4:0] decim // Lane decimation ratio
);

    // ----------
    // Helpers
    // ----------
    // Doubling with saturation, so 6 dB never wraps the sign
    function [W-1:0] sat_dbl;
        input [W-1:0] x;
        begin
            if (x[W-1] != x[W-2])
                sat_dbl = x[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
            else
                sat_dbl = {x[W-2:0], 1'b0};
        end
    endfunction

    // Half-band stages in use: code 0,1,2,3 gives 2,3,4,1
    wire [2:0] stages = (chain_code == 2'b11) ? 3'd1 : ({1'b0, chain_code} + 3'd2);
    // Real output bypasses the last downsample by 2
    wire [2:0] dexp = real_out ? (stages - 3'd1) : stages;
    assign decim = 5'h01 << dexp;

    // ----------
    // Routing and gain
    // ----------
    wire [W-1:0] in_i = sel_i_b ? sample_b : sample_a;
    // A real mixer has only one real input
    wire [W-1:0] in_q = complex_mixer ? (sel_q_b ? sample_b : sample_a) : {W{1'b0}};
    wire [W-1:0] g_i = gain_6db ? sat_dbl(in_i) : in_i;
    wire [W-1:0] g_q = gain_6db ? sat_dbl(in_q) : in_q;

    reg [3:0] cnt_q; // Decimation phase
    reg [1:0] rot_q; // Quarter-rate rotation phase

    // Keep one sample in every decim, rotate by fs/4 for real output
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            rot_q <= 2'b00;
            out_i <= {W{1'b0}};
            out_q <= {W{1'b0}};
            out_valid <= 1'b0;
        end else begin
            out_valid <= 1'b0;
            if (!enable) begin
                cnt_q <= 4'h0;
                rot_q <= 2'b00;
            end else if (sample_valid) begin
                cnt_q <= (cnt_q == decim[3:0] - 4'h1) ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == 4'h0) begin
                    out_valid <= 1'b1;
                    if (real_out) begin
                        // Upconvert by fs/4 and keep the real part, Q dropped
                        rot_q <= rot_q + 2'b01;
                        case (rot_q)
                            2'b00: out_i <= g_i;
                            2'b01: out_i <= -g_q;
                            2'b10: out_i <= -g_i;
                            default: out_i <= g_q;
                        endcase
                        out_q <= {W{1'b0}};
                    end else begin
                        out_i <= g_i;
                        out_q <= g_q;
                    end
                end
            end
        end
    end

endmodule // ddcm_path

// [ddcm_top.v]
// Downconverter mode configuration: registers, mode decode and two lanes
`timescale 1ns/1ps
`include "ddcm_regs.vh"

module ddcm_top #(
    parameter W = 14 // Converter sample width
) (
    input wire clock, // System clock, 250 MHz
    input wire rst_b, // Asynchronous reset, active low
    input wire hsel, // AHB slave select
    input wire [31:0] haddr, // AHB byte address
    input wire [1:0] htrans, // AHB transfer type
    input wire hwrite, // AHB write
    input wire [2:0] hsize, // AHB size
    input wire [31:0] hwdata, // AHB write data
    input wire hready, // AHB ready in
    output wire hreadyout, // AHB ready out
    output wire hresp, // AHB response
    output wire [31:0] hrdata, // AHB read data
    input wire [W-1:0] sample_a, // Converter channel A
    input wire [W-1:0] sample_b, // Converter channel B
    input wire sample_valid, // Sample strobe
    output wire [W-1:0] ddc0_i, // Lane 0 I or real data
    output wire [W-1:0] ddc0_q, // Lane 0 Q data
    output wire ddc0_i_valid, // Lane 0 I strobe
    output wire ddc0_q_valid, // Lane 0 Q strobe
    output wire [W-1:0] ddc1_i, // Lane 1 I or real data
    output wire [W-1:0] ddc1_q, // Lane 1 Q data
    output wire ddc1_i_valid, // Lane 1 I strobe
    output wire ddc1_q_valid, // Lane 1 Q strobe
    output reg [15:0] frequency_tuning_word0, // Lane 0 tuning word
    output reg [15:0] phase_offset_word0, // Lane 0 phase word
    output reg [15:0] frequency_tuning_word1, // Lane 1 tuning word
    output reg [15:0] phase_offset_word1, // Lane 1 phase word
    output reg [1:0] active_ddc_count, // Lanes running
    output reg i_only, // Q paths muted
    output reg [2:0] chip_decimation // Chip decimation ratio
);

    // ----------
    // Bus front end
    // ----------
    wire wr_en; // Data-phase write strobe
    wire [9:0] wr_idx; // Index being written
    wire [7:0] wr_data; // Byte being written
    wire [9:0] rd_idx; // Index being read
    reg [7:0] rd_data; // Read byte for the slave

    ddcm_ahb_slave u_bus (
        .clock(clock),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // ----------
    // Register storage
    // ----------
    reg [7:0] app_q; // Chip application select
    reg [7:0] dec_q; // Chip decimation select
    reg [7:0] ctl0_q; // Lane 0 control
    reg [7:0] sel0_q; // Lane 0 input select
    reg [7:0] ftwa0_q; // Lane 0 tuning word, low byte
    reg [7:0] ftwb0_q; // Lane 0 tuning word, high byte
    reg [7:0] powa0_q; // Lane 0 phase word, low byte
    reg [7:0] powb0_q; // Lane 0 phase word, high byte
    reg [7:0] ctl1_q; // Lane 1 control
    reg [7:0] sel1_q; // Lane 1 input select
    reg [7:0] ftwa1_q; // Lane 1 tuning word, low byte
    reg [7:0] ftwb1_q; // Lane 1 tuning word, high byte
    reg [7:0] powa1_q; // Lane 1 phase word, low byte
    reg [7:0] powb1_q; // Lane 1 phase word, high byte

    // Byte writes; unmapped indices are dropped without error
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            app_q <= `DDCM_RST_APP;
            dec_q <= `DDCM_RST_DEC;
            ctl0_q <= `DDCM_RST_CTL;
            sel0_q <= `DDCM_RST_SEL;
            ftwa0_q <= `DDCM_RST_WORD;
            ftwb0_q <= `DDCM_RST_WORD;
            powa0_q <= `DDCM_RST_WORD;
            powb0_q <= `DDCM_RST_WORD;
            ctl1_q <= `DDCM_RST_CTL;
            sel1_q <= `DDCM_RST_SEL;
            ftwa1_q <= `DDCM_RST_WORD;
            ftwb1_q <= `DDCM_RST_WORD;
            powa1_q <= `DDCM_RST_WORD;
            powb1_q <= `DDCM_RST_WORD;
        end else if (wr_en) begin
            case (wr_idx)
                `DDCM_IDX_APP: app_q <= wr_data;
                `DDCM_IDX_DEC: dec_q <= wr_data;
                `DDCM_IDX_CTL0: ctl0_q <= wr_data;
                `DDCM_IDX_SEL0: sel0_q <= wr_data;
                `DDCM_IDX_FTWA0: ftwa0_q <= wr_data;
                `DDCM_IDX_FTWB0: ftwb0_q <= wr_data;
                `DDCM_IDX_POWA0: powa0_q <= wr_data;
                `DDCM_IDX_POWB0: powb0_q <= wr_data;
                `DDCM_IDX_CTL1: ctl1_q <= wr_data;
                `DDCM_IDX_SEL1: sel1_q <= wr_data;
                `DDCM_IDX_FTWA1: ftwa1_q <= wr_data;
                `DDCM_IDX_FTWB1: ftwb1_q <= wr_data;
                `DDCM_IDX_POWA1: powa1_q <= wr_data;
                `DDCM_IDX_POWB1: powb1_q <= wr_data;
                default: ;
            endcase
        end
    end

    // ----------
    // Mode decode
    // ----------
    reg app_ok; // Application code is one we support
    reg dec_ok; // Decimation code is one we support
    reg [1:0] count_d; // Lanes to run
    reg i_only_d; // Q paths muted
    reg [2:0] ratio_d; // Chip decimation ratio

    // Unknown code: one lane, I/Q, status flag
    always @* begin
        app_ok = 1'b1;
        count_d = 2'd1;
        i_only_d = 1'b0;
        case (app_q)
            `DDCM_APP_ONE_IQ: count_d = 2'd1;
            `DDCM_APP_TWO_IQ: count_d = 2'd2;
            `DDCM_APP_TWO_I: begin
                count_d = 2'd2;
                i_only_d = 1'b1;
            end
            default: app_ok = 1'b0;
        endcase
    end

    // Chip decimation: only by 2 and by 4 are supported here
    always @* begin
        dec_ok = 1'b1;
        ratio_d = 3'd2;
        case (dec_q)
            `DDCM_DEC_BY2: ratio_d = 3'd2;
            `DDCM_DEC_BY4: ratio_d = 3'd4;
            default: dec_ok = 1'b0;
        endcase
    end

    // Registered so lane controls and status see a steady decode
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            active_ddc_count <= 2'd1;
            i_only <= 1'b0;
            chip_decimation <= 3'd2;
        end else begin
            active_ddc_count <= count_d;
            i_only <= i_only_d;
            chip_decimation <= ratio_d;
        end
    end

    // Word outputs assembled from their byte halves
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            frequency_tuning_word0 <= 16'h0000;
            phase_offset_word0 <= 16'h0000;
            frequency_tuning_word1 <= 16'h0000;
            phase_offset_word1 <= 16'h0000;
        end else begin
            frequency_tuning_word0 <= {ftwb0_q, ftwa0_q};
            phase_offset_word0 <= {powb0_q, powa0_q};
            frequency_tuning_word1 <= {ftwb1_q, ftwa1_q};
            phase_offset_word1 <= {powb1_q, powa1_q};
        end
    end

    // ----------
    // Lanes
    // ----------
    // Control bits drive the lane fields
    wire [4:0] decim0; // Lane 0 ratio
    wire [4:0] decim1; // Lane 1 ratio
    wire v0; // Lane 0 strobe
    wire v1; // Lane 1 strobe
    wire run1 = (active_ddc_count == 2'd2); // Lane 1 only in two-lane modes

    ddcm_path #(.W(W)) u_ddc0 (
        .clock(clock),
        .rst_b(rst_b),
        .enable(1'b1),
        .sample_a(sample_a),
        .sample_b(sample_b),
        .sample_valid(sample_valid),
        .sel_i_b(sel0_q[`DDCM_SEL_I]),
        .sel_q_b(sel0_q[`DDCM_SEL_Q]),
        .complex_mixer(ctl0_q[`DDCM_CTL_CMIX]),
        .gain_6db(ctl0_q[`DDCM_CTL_GAIN]),
        .real_out(ctl0_q[`DDCM_CTL_REAL]),
        .chain_code(ctl0_q[`DDCM_CTL_CHAIN_HI:`DDCM_CTL_CHAIN_LO]),
        .out_i(ddc0_i),
        .out_q(ddc0_q),
        .out_valid(v0),
        .decim(decim0)
    );

    ddcm_path #(.W(W)) u_ddc1 (
        .clock(clock),
        .rst_b(rst_b),
        .enable(run1),
        .sample_a(sample_a),
        .sample_b(sample_b),
        .sample_valid(sample_valid),
        .sel_i_b(sel1_q[`DDCM_SEL_I]),
        .sel_q_b(sel1_q[`DDCM_SEL_Q]),
        .complex_mixer(ctl1_q[`DDCM_CTL_CMIX]),
        .gain_6db(ctl1_q[`DDCM_CTL_GAIN]),
        .real_out(ctl1_q[`DDCM_CTL_REAL]),
        .chain_code(ctl1_q[`DDCM_CTL_CHAIN_HI:`DDCM_CTL_CHAIN_LO]),
        .out_i(ddc1_i),
        .out_q(ddc1_q),
        .out_valid(v1),
        .decim(decim1)
    );

    // ----------
    // Output strobes
    // ----------
    // I-only mode mutes Q strobes; real-output lanes never flag Q
    assign ddc0_i_valid = v0;
    assign ddc0_q_valid = v0 & ~i_only & ~ctl0_q[`DDCM_CTL_REAL];
    assign ddc1_i_valid = v1 & run1;
    assign ddc1_q_valid = v1 & run1 & ~i_only & ~ctl1_q[`DDCM_CTL_REAL];

    // ----------
    // Status
    // ----------
    // A lane ratio off the chip ratio upsets
    // the serial transport; flagged for software
    wire match0 = (decim0 == {2'b00, chip_decimation});
    wire match1 = (decim1 == {2'b00, chip_decimation}) | ~run1;
    wire [7:0] status = {3'b000, ~match1, ~match0, ~dec_ok, ~app_ok, run1};

    // ----------
    // Read mux
    // ----------
    // Unmapped indices read as zero
    always @* begin
        case (rd_idx)
            `DDCM_IDX_APP: rd_data = app_q;
            `DDCM_IDX_DEC: rd_data = dec_q;
            `DDCM_IDX_STATUS: rd_data = status;
            `DDCM_IDX_CTL0: rd_data = ctl0_q;
            `DDCM_IDX_SEL0: rd_data = sel0_q;
            `DDCM_IDX_FTWA0: rd_data = ftwa0_q;
            `DDCM_IDX_FTWB0: rd_data = ftwb0_q;
            `DDCM_IDX_POWA0: rd_data = powa0_q;
            `DDCM_IDX_POWB0: rd_data = powb0_q;
            `DDCM_IDX_CTL1: rd_data = ctl1_q;
            `DDCM_IDX_SEL1: rd_data = sel1_q;
            `DDCM_IDX_FTWA1: rd_data = ftwa1_q;
            `DDCM_IDX_FTWB1: rd_data = ftwb1_q;
            `DDCM_IDX_POWA1: rd_data = powa1_q;
            `DDCM_IDX_POWB1: rd_data = powb1_q;
            default: rd_data = 8'h00;
        endcase
    end

endmodule // ddcm_top

// [ddcm_top_chk.sv]
// Assertion checker for the downconverter mode block
`timescale 1ns/1ps

module ddcm_chk (
    input wire clock, // System clock
    input wire rst_b, // Reset, active low
    input wire hsel, // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write
    input wire hready, // Bus ready
    input wire [31:0] hwdata, // Write data
    input wire ddc0_q_valid, // Lane 0 Q strobe
    input wire ddc1_i_valid, // Lane 1 I strobe
    input wire ddc1_q_valid, // Lane 1 Q strobe
    input wire [15:0] frequency_tuning_word0, // Lane 0 tuning word
    input wire [15:0] phase_offset_word1, // Lane 1 phase word
    input wire [1:0] active_ddc_count, // Lanes running
    input wire i_only, // Q paths muted
    input wire [2:0] chip_decimation // Chip ratio
);
    // ----------
    // Write tracking
    // ----------
    reg wr_q; // Mapped write in its data phase
    reg [9:0] idx_q; // Index of that write
    reg [7:0] wd_q; // Byte of the last write, held for late checks
    wire [7:0] wd = hwdata[7:0]; // Byte on the bus now
    // Address phase is only taken with hready high
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            idx_q <= 10'h000;
            wd_q <= 8'h00;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite && haddr[31:12] == 20'h00000;
            idx_q <= haddr[11:2];
            if (wr_q) wd_q <= wd;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------
    // Properties
    // ----------
    AST_APP_ONE: assert property (wr_q && idx_q == 10'h200 && wd == 8'h01
        |-> ##[1:3] active_ddc_count == 2'h1 && !i_only) else $error("one lane code ignored");
    AST_APP_TWO: assert property (wr_q && idx_q == 10'h200 && wd == 8'h02
        |-> ##[1:3] active_ddc_count == 2'h2 && !i_only) else $error("two lane code ignored");
    AST_APP_IONLY: assert property (wr_q && idx_q == 10'h200 && wd == 8'h22
        |-> ##[1:3] active_ddc_count == 2'h2 && i_only) else $error("I only code ignored");
    AST_DEC_TWO: assert property (wr_q && idx_q == 10'h201 && wd == 8'h01
        |-> ##[1:3] chip_decimation == 3'h2) else $error("ratio two missing");
    AST_DEC_FOUR: assert property (wr_q && idx_q == 10'h201 && wd == 8'h02
        |-> ##[1:3] chip_decimation == 3'h4) else $error("ratio four missing");
    AST_TUNE0: assert property (wr_q && idx_q == 10'h314
        |-> ##[2:3] frequency_tuning_word0[7:0] == wd_q) else $error("tuning byte lost");
    AST_PHASE1: assert property (wr_q && idx_q == 10'h341
        |-> ##[2:3] phase_offset_word1[15:8] == wd_q) else $error("phase byte lost");
    AST_IONLY_MUTE: assert property (i_only |-> !ddc0_q_valid && !ddc1_q_valid)
        else $error("Q strobe in I only mode");
    AST_LANE1_IDLE: assert property (active_ddc_count == 2'h1 && $past(active_ddc_count) == 2'h1
        |-> !ddc1_i_valid) else $error("idle lane produced data");
    // Main scenarios reached
    cover property (wr_q && idx_q == 10'h200 && wd == 8'h22);
    cover property (ddc0_q_valid);
    cover property (ddc1_i_valid && i_only);
endmodule // ddcm_chk

bind ddcm_top ddcm_chk ddcm_chk_i (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .ddc0_q_valid(ddc0_q_valid), .ddc1_i_valid(ddc1_i_valid), .ddc1_q_valid(ddc1_q_valid),
    .frequency_tuning_word0(frequency_tuning_word0), .phase_offset_word1(phase_offset_word1),
    .active_ddc_count(active_ddc_count), .i_only(i_only), .chip_decimation(chip_decimation));

// [ddcm_top_bench.sv]
// Self-checking testbench for the downconverter mode block
`timescale 1ns/1ps
`include "ddcm_regs.vh"

module ddcm_top_bench;
    reg clock = 1'b0; // 250 MHz clock
    reg rst_b = 1'b0; // Reset, active low
    reg hsel = 1'b0; // Select
    reg [31:0] haddr = 32'h00000000; // Byte address
    reg [1:0] htrans = 2'h0; // Transfer type
    reg hwrite = 1'b0; // Write
    reg [31:0] hwdata = 32'h00000000; // Write data
    reg [13:0] sample_a = 14'h0000; // Channel A
    reg [13:0] sample_b = 14'h0000; // Channel B
    reg sample_valid = 1'b0; // Sample strobe
    wire hreadyout, hresp;
    wire [31:0] hrdata;
    wire [13:0] d0i, d0q, d1i, d1q;
    wire d0iv, d0qv, d1iv, d1qv;
    wire [15:0] ftw0, pow0, ftw1, pow1;
    wire [1:0] active_ddc_count;
    wire i_only;
    wire [2:0] chip_decimation;
    integer err_total = 0; // Mismatches
    integer check_count = 0; // Comparisons
    reg [31:0] lfsr_q = 32'h000028EC; // Random source
    reg [31:0] rd_q [$]; // Expected read data
    reg [29:0] lane_q [2][$]; // Expected lane results {check, qvalid, i, q}
    reg rd_ph = 1'b0; // Read in its data phase
    reg [29:0] e; // Popped note
    integer k, n;
    reg [7:0] wb [8]; // Written word bytes
    reg [9:0] widx [8] = '{`DDCM_IDX_FTWA0, `DDCM_IDX_FTWB0, `DDCM_IDX_POWA0, `DDCM_IDX_POWB0,
        `DDCM_IDX_FTWA1, `DDCM_IDX_FTWB1, `DDCM_IDX_POWA1, `DDCM_IDX_POWB1};
    wire [1:0] iv = {d1iv, d0iv};
    wire [1:0] qv = {d1qv, d0qv};
    wire [27:0] iq [2];
    assign iq[0] = {d0i, d0q};
    assign iq[1] = {d1i, d1q};

    always #2 clock = ~clock;

    // Bus ready loops back from the only slave; word size is the only size used
    ddcm_top #(.W(14)) ddcm_top_i (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_a(sample_a),
        .sample_b(sample_b), .sample_valid(sample_valid), .ddc0_i(d0i), .ddc0_q(d0q),
        .ddc0_i_valid(d0iv), .ddc0_q_valid(d0qv), .ddc1_i(d1i), .ddc1_q(d1q),
        .ddc1_i_valid(d1iv), .ddc1_q_valid(d1qv), .frequency_tuning_word0(ftw0),
        .phase_offset_word0(pow0), .frequency_tuning_word1(ftw1), .phase_offset_word1(pow1),
        .active_ddc_count(active_ddc_count), .i_only(i_only), .chip_decimation(chip_decimation));

    // ----------
    // Helpers
    // ----------
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Saturating doubling of a signed sample
    function [13:0] dbl(input [13:0] x);
        dbl = (x[13] != x[12]) ? (x[13] ? 14'h2000 : 14'h1FFF) : {x[12:0], 1'b0};
    endfunction

    task cmp(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Waits for an edge with ready high; a stuck bus ends the run
    task wait_rdy;
        integer w;
        begin
            w = 0;
            @(posedge clock);
            while (hreadyout !== 1'b1 && w < 20) begin
                @(posedge clock);
                w = w + 1;
            end
            if (w == 20) begin
                err_total = err_total + 1;
                stop_test;
            end
        end
    endtask

    // One single word transfer; on a read d is the expected byte
    task bus(input wr, input [31:0] addr, input [7:0] d);
        begin
            if (!wr) rd_q.push_back({24'h000000, d});
            @(posedge clock);
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= addr;
            hwrite <= wr;
            wait_rdy;
            htrans <= 2'h0;
            hwdata <= {24'h000000, d};
            wait_rdy;
        end
    endtask

    // Configure both lanes, stream 16 constant samples and note every expected output
    task run(input [7:0] app, input [7:0] ctl, input [7:0] s0, input [7:0] s1);
        integer j, st, dec;
        reg [13:0] vi, vq;
        reg [7:0] sel;
        begin
            bus(1, `DDCM_IDX_APP * 4, app);
            bus(1, `DDCM_IDX_CTL0 * 4, ctl);
            bus(1, `DDCM_IDX_CTL1 * 4, ctl);
            bus(1, `DDCM_IDX_SEL0 * 4, s0);
            bus(1, `DDCM_IDX_SEL1 * 4, s1);
            cmp({i_only, active_ddc_count}, {app == 8'h22, app == 8'h01 ? 2'h1 : 2'h2});
            lfsr_q = lfsr_next(lfsr_q);
            sample_a <= lfsr_q[13:0];
            sample_b <= lfsr_q[27:14];
            st = (ctl[1:0] == 2'h3) ? 1 : ctl[1:0] + 2;
            dec = 1 << (st - ctl[3]);
            for (j = 0; j < 2; j = j + 1) begin
                sel = j ? s1 : s0;
                vi = sel[0] ? lfsr_q[27:14] : lfsr_q[13:0];
                vq = !ctl[7] ? 14'h0000 : (sel[2] ? lfsr_q[27:14] : lfsr_q[13:0]);
                if (ctl[6]) begin
                    vi = dbl(vi);
                    vq = dbl(vq);
                end
                // Real output values depend on the mixer phase, so only strobes are noted
                if (j == 0 || app != 8'h01)
                    for (n = 0; n < 16 / dec; n = n + 1)
                        lane_q[j].push_back({!ctl[3], !ctl[3] && app != 8'h22,
                            ctl[3] ? 28'h0000000 : {vi, vq}});
            end
            for (n = 0; n < 16; n = n + 1) begin
                @(posedge clock);
                sample_valid <= 1'b1;
            end
            @(posedge clock);
            sample_valid <= 1'b0;
            repeat (6) @(posedge clock);
            cmp(lane_q[0].size(), 0);
            cmp(lane_q[1].size(), 0);
            $display("test mode %h done", ctl);
        end
    endtask

    // ----------
    // Monitor: match each result with the oldest note
    // ----------
    always @(posedge clock) begin
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
        if (rd_ph && hreadyout) cmp(hrdata, rd_q.pop_front());
        for (k = 0; k < 2; k = k + 1) begin
            if (iv[k] === 1'b1) begin
                if (lane_q[k].size() == 0) cmp(32'h1, 32'h0);
                else begin
                    e = lane_q[k].pop_front();
                    cmp({qv[k], e[29] ? iq[k] : 28'h0000000}, e[28:0]);
                end
            end
        end
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        bus(0, `DDCM_IDX_APP * 4, 8'h01);
        bus(0, `DDCM_IDX_DEC * 4, 8'h01);
        bus(0, `DDCM_IDX_CTL1 * 4, 8'h83);
        bus(0, `DDCM_IDX_SEL0 * 4, 8'h04);
        bus(0, 32'h00010800, 8'h00);
        bus(0, `DDCM_IDX_STATUS * 4, 8'h00);
        cmp(chip_decimation, 3'h2);
        $display("test reset done");
        bus(1, `DDCM_IDX_DEC * 4, 8'h02);
        repeat (3) @(posedge clock);
        cmp(chip_decimation, 3'h4);
        bus(1, `DDCM_IDX_DEC * 4, 8'h01);
        repeat (3) @(posedge clock);
        cmp(chip_decimation, 3'h2);
        $display("test decimation done");
        for (n = 0; n < 8; n = n + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            wb[n] = lfsr_q[7:0];
            bus(1, widx[n] * 4, wb[n]);
            bus(0, widx[n] * 4, wb[n]);
        end
        repeat (3) @(posedge clock);
        cmp({ftw0, pow0}, {wb[1], wb[0], wb[3], wb[2]});
        cmp({ftw1, pow1}, {wb[5], wb[4], wb[7], wb[6]});
        $display("test words done");
        run(8'h01, 8'h83, 8'h04, 8'h04);
        run(8'h02, 8'h80, 8'h04, 8'h04);
        run(8'h22, 8'h89, 8'h04, 8'h04);
        run(8'h22, 8'h49, 8'h00, 8'h05);
        run(8'h02, 8'h40, 8'h00, 8'h05);
        stop_test;
    end
endmodule // ddcm_top_bench
